// >>> omca_pkg.sv
/*
 * Shared constants and types for the output macro cell array.
 * Assumes one 100 MHz clock and a synchronous, active-high reset.
 */
package omca_pkg;

    // ****************************************************************
    // Array shape
    // ****************************************************************
    localparam int N_CELLS        = 8;
    localparam int TERMS_PER_CELL = 9;
    localparam int SUM_TERMS      = 8;
    localparam int DIR_TERM_IDX   = 8;
    localparam int N_TERMS        = 72;
    localparam int CFG_BITS       = 26;

    // ****************************************************************
    // Cell modes, coded as {arch_select_bit_a, arch_select_bit_b}
    // ****************************************************************
    localparam logic [1:0] MODE_REGISTERED = 2'h0;
    localparam logic [1:0] MODE_INPUT      = 2'h1;
    localparam logic [1:0] MODE_COMB       = 2'h2;
    localparam logic [1:0] MODE_BIDIR      = 2'h3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic RST_Q        = 1'b0;
    localparam logic RST_PIN_PREV = 1'b0;
    localparam logic RST_RB_VALID = 1'b0;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        OMCA_REGISTERED,
        OMCA_INPUT,
        OMCA_COMB,
        OMCA_BIDIR
    } omca_mode_t;

    typedef struct packed {
        logic arch_select_bit_a;
        logic arch_select_bit_b;
        logic polarity_select_bit;
    } omca_cell_cfg_t;

    typedef struct packed {
        logic preset_term;
        logic reset_term;
        logic clk_edge;
        logic shared_oe;
    } omca_ctrl_t;

    function automatic omca_mode_t omca_decode_mode(input omca_cell_cfg_t cfg);
        logic [1:0] code;
        code = {cfg.arch_select_bit_a, cfg.arch_select_bit_b};
        case (code)
            MODE_REGISTERED: omca_decode_mode = OMCA_REGISTERED;
            MODE_INPUT:      omca_decode_mode = OMCA_INPUT;
            MODE_COMB:       omca_decode_mode = OMCA_COMB;
            default:         omca_decode_mode = OMCA_BIDIR;
        endcase
    endfunction

endpackage

// >>> omca_cell.sv
/*
 * One output cell: sum term, optional flip-flop, polarity and pin driver.
 * Assumes the caller supplies a one-cycle clock-edge strobe and shared terms.
 */
module omca_cell (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Terms and configuration
    input  wire logic [8:0]              terms_i,
    input  wire omca_pkg::omca_cell_cfg_t cfg_i,
    input  wire omca_pkg::omca_ctrl_t    ctrl_i,
    // Pin
    input  wire logic                    pin_i,
    output logic                         pin_o,
    output logic                         pin_oe_o,
    // Feedback to the array
    output logic                         fb_o
);

    // ****************************************************************
    // Sum term and mode
    // ****************************************************************
    omca_pkg::omca_mode_t mode;
    logic                 sum;
    logic                 q_reg;
    logic                 q_next;

    assign mode = omca_pkg::omca_decode_mode(cfg_i);
    assign sum  = |terms_i[omca_pkg::SUM_TERMS-1:0];

    // ****************************************************************
    // Flip-flop
    // ****************************************************************
    always_comb begin
        q_next = q_reg;
        if (ctrl_i.reset_term) begin
            q_next = omca_pkg::RST_Q;
        end else if (mode == omca_pkg::OMCA_REGISTERED && ctrl_i.clk_edge) begin
            if (ctrl_i.preset_term) begin
                q_next = 1'b1;
            end else begin
                q_next = cfg_i.polarity_select_bit ? sum : ~sum;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= omca_pkg::RST_Q;
        end else begin
            q_reg <= q_next;
        end
    end

    // ****************************************************************
    // Pin driver and feedback
    // ****************************************************************
    always_comb begin
        pin_o    = 1'b0;
        pin_oe_o = 1'b0;
        fb_o     = pin_i;
        case (mode)
            omca_pkg::OMCA_REGISTERED: begin
                pin_o    = ~(q_reg & ~ctrl_i.reset_term);
                pin_oe_o = ctrl_i.shared_oe;
                fb_o     = q_reg & ~ctrl_i.reset_term;
            end
            omca_pkg::OMCA_COMB: begin
                pin_o    = cfg_i.polarity_select_bit ? ~sum : sum;
                pin_oe_o = 1'b1;
            end
            omca_pkg::OMCA_BIDIR: begin
                pin_o    = cfg_i.polarity_select_bit ? ~sum : sum;
                pin_oe_o = terms_i[omca_pkg::DIR_TERM_IDX];
            end
            default: begin
                pin_o    = 1'b0;
                pin_oe_o = 1'b0;
            end
        endcase
    end

endmodule

// >>> omca_top.sv
/*
 * Output stage of a small programmable logic array: eight output cells,
 * shared preset and reset terms, a global pin configuration cell and a
 * readback port guarded by a security fuse.
 * Assumes all inputs, including the dedicated clock pin, are synchronous
 * to clk_i and that the AND array lies outside this block.
 */
// Function
// - Eight cells, nine terms each, seventy-two total
// - Eight terms sum; ninth enables pin driver in bidirectional mode
// - Shared terms: synchronous preset, asynchronous reset
// - Two architecture bits per cell, four modes
// - Per-cell polarity bit inverts or passes output
// - Programmed global cell: clock and enable pins
// - Unprogrammed global cell: both pins plain inputs
// - Registered cells share the dedicated enable pin
// - Bidirectional cells enabled by direction term only
// - Unprogrammed array drives every term low
// - Unprogrammed cells are bidirectional, driver disabled
// - Programmed security fuse refuses all readback
// - Power-up clears registers; registered pins read high
// - Registered cells feed state back, low after reset
module omca_top #(
    parameter int N_CELLS        = omca_pkg::N_CELLS,
    parameter int TERMS_PER_CELL = omca_pkg::TERMS_PER_CELL
) (
    // Clock and reset
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_i,
    // Product terms from the AND array
    input  wire logic [N_CELLS*TERMS_PER_CELL-1:0]    pterm_i,
    input  wire logic                                 preset_term_i,
    input  wire logic                                 reset_term_i,
    input  wire logic                                 array_programmed_i,
    // Configuration
    input  wire logic [N_CELLS-1:0]                   arch_select_bit_a_i,
    input  wire logic [N_CELLS-1:0]                   arch_select_bit_b_i,
    input  wire logic [N_CELLS-1:0]                   polarity_select_bit_i,
    input  wire logic                                 global_cfg_programmed_i,
    input  wire logic                                 security_fuse_i,
    // Dedicated pins
    input  wire logic                                 clock_pin_i,
    input  wire logic                                 shared_enable_pin_n_i,
    // Cell pins
    input  wire logic [N_CELLS-1:0]                   cell_pin_i,
    output logic      [N_CELLS-1:0]                   cell_pin_o,
    output logic      [N_CELLS-1:0]                   cell_pin_oe_o,
    // Feedback and dedicated-pin inputs to the AND array
    output logic      [N_CELLS-1:0]                   feedback_o,
    output logic      [1:0]                           dedicated_in_o,
    // Readback port
    input  wire logic                                 readback_req_i,
    output logic      [omca_pkg::CFG_BITS-1:0]        readback_data_o,
    output logic                                      readback_valid_o,
    output logic                                      readback_refused_o
);

    // ****************************************************************
    // Term gating
    // ****************************************************************
    logic [N_CELLS*TERMS_PER_CELL-1:0] terms;
    logic                              preset_term;
    logic                              reset_term;

    always_comb begin
        terms       = pterm_i & {(N_CELLS*TERMS_PER_CELL){array_programmed_i}};
        preset_term = preset_term_i & array_programmed_i;
        reset_term  = reset_term_i & array_programmed_i;
    end

    // ****************************************************************
    // Dedicated pins
    // ****************************************************************
    logic clk_pin_prev_reg;
    logic clk_pin_prev_next;
    logic clk_edge;
    logic shared_oe;

    always_comb begin
        clk_pin_prev_next = clock_pin_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_pin_prev_reg <= omca_pkg::RST_PIN_PREV;
        end else begin
            clk_pin_prev_reg <= clk_pin_prev_next;
        end
    end

    always_comb begin
        clk_edge  = global_cfg_programmed_i & clock_pin_i & ~clk_pin_prev_reg;
        shared_oe = global_cfg_programmed_i & ~shared_enable_pin_n_i;
        if (global_cfg_programmed_i) begin
            dedicated_in_o = 2'h0;
        end else begin
            dedicated_in_o = {shared_enable_pin_n_i, clock_pin_i};
        end
    end

    // ****************************************************************
    // Shared control
    // ****************************************************************
    omca_pkg::omca_ctrl_t ctrl;

    always_comb begin
        ctrl.preset_term = preset_term;
        ctrl.reset_term  = reset_term;
        ctrl.clk_edge    = clk_edge;
        ctrl.shared_oe   = shared_oe;
    end

    // ****************************************************************
    // Output cells
    // ****************************************************************
    omca_pkg::omca_cell_cfg_t cell_cfg [N_CELLS];

    for (genvar c = 0; c < N_CELLS; c++) begin : g_cell
        always_comb begin
            cell_cfg[c].arch_select_bit_a   = arch_select_bit_a_i[c];
            cell_cfg[c].arch_select_bit_b   = arch_select_bit_b_i[c];
            cell_cfg[c].polarity_select_bit = polarity_select_bit_i[c];
        end

        omca_cell omca_cell_inst (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .terms_i  (terms[c*TERMS_PER_CELL +: TERMS_PER_CELL]),
            .cfg_i    (cell_cfg[c]),
            .ctrl_i   (ctrl),
            .pin_i    (cell_pin_i[c]),
            .pin_o    (cell_pin_o[c]),
            .pin_oe_o (cell_pin_oe_o[c]),
            .fb_o     (feedback_o[c])
        );
    end

    // ****************************************************************
    // Readback
    // ****************************************************************
    logic [omca_pkg::CFG_BITS-1:0] cfg_word;
    logic [omca_pkg::CFG_BITS-1:0] rb_data_reg;
    logic [omca_pkg::CFG_BITS-1:0] rb_data_next;
    logic                          rb_valid_reg;
    logic                          rb_valid_next;
    logic                          rb_refused_reg;
    logic                          rb_refused_next;

    always_comb begin
        cfg_word = {security_fuse_i, global_cfg_programmed_i,
                    polarity_select_bit_i, arch_select_bit_b_i, arch_select_bit_a_i};
    end

    always_comb begin
        rb_data_next    = rb_data_reg;
        rb_valid_next   = omca_pkg::RST_RB_VALID;
        rb_refused_next = 1'b0;
        if (readback_req_i) begin
            if (security_fuse_i) begin
                rb_data_next    = '0;
                rb_refused_next = 1'b1;
            end else begin
                rb_data_next  = cfg_word;
                rb_valid_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rb_data_reg    <= '0;
            rb_valid_reg   <= omca_pkg::RST_RB_VALID;
            rb_refused_reg <= 1'b0;
        end else begin
            rb_data_reg    <= rb_data_next;
            rb_valid_reg   <= rb_valid_next;
            rb_refused_reg <= rb_refused_next;
        end
    end

    always_comb begin
        readback_data_o    = rb_data_reg;
        readback_valid_o   = rb_valid_reg;
        readback_refused_o = rb_refused_reg;
    end

endmodule

// >>> omca_top_sva.sv
/*
 * Checker for the output cell array, watching the top module's ports.
 * Assumes one clock domain with a synchronous active-high reset.
 */
module omca_chk #(
    parameter int N_CELLS        = 8,
    parameter int TERMS_PER_CELL = 9
) (
    // Clock and reset
    input wire logic                              clk_i,
    input wire logic                              rst_i,
    // Terms and configuration
    input wire logic [N_CELLS*TERMS_PER_CELL-1:0] pterm_i,
    input wire logic                              preset_term_i,
    input wire logic                              reset_term_i,
    input wire logic                              array_programmed_i,
    input wire logic [N_CELLS-1:0]                arch_select_bit_a_i,
    input wire logic [N_CELLS-1:0]                arch_select_bit_b_i,
    input wire logic [N_CELLS-1:0]                polarity_select_bit_i,
    input wire logic                              global_cfg_programmed_i,
    input wire logic                              security_fuse_i,
    // Pins and outputs
    input wire logic                              clock_pin_i,
    input wire logic                              shared_enable_pin_n_i,
    input wire logic [N_CELLS-1:0]                cell_pin_o,
    input wire logic [N_CELLS-1:0]                cell_pin_oe_o,
    input wire logic [N_CELLS-1:0]                feedback_o,
    input wire logic [1:0]                        dedicated_in_o,
    input wire logic                              readback_req_i,
    input wire logic [25:0]                       readback_data_o,
    input wire logic                              readback_refused_o
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic prog_rst;
    logic prog_pre;
    assign prog_rst = array_programmed_i & reset_term_i;
    assign prog_pre = array_programmed_i & preset_term_i;
    sequence s_edge;
        global_cfg_programmed_i && $rose(clock_pin_i);
    endsequence
    AST_DED_IN: assert property (dedicated_in_o == (global_cfg_programmed_i ? 2'h0 :
        {shared_enable_pin_n_i, clock_pin_i})) else $error("dedicated inputs wrong");
    AST_RB_REFUSE: assert property (readback_req_i && security_fuse_i
        |=> readback_refused_o && readback_data_o == 26'h0) else $error("readback not refused");
    for (genvar c = 0; c < N_CELLS; c++) begin : g_cell
        logic [1:0] m;
        logic       s;
        logic       q_exp;
        logic       skip;
        assign m = {arch_select_bit_a_i[c], arch_select_bit_b_i[c]};
        assign s = array_programmed_i & (|pterm_i[c*TERMS_PER_CELL +: 8]);
        assign q_exp = ~(s ^ polarity_select_bit_i[c]);
        assign skip = prog_rst | (m != 2'h0);
        AST_REG_CAPTURE: assert property ((m == 2'h0 && !prog_rst && !prog_pre) ##0 s_edge
            |=> skip || (feedback_o[c] == $past(q_exp) && cell_pin_o[c] != feedback_o[c]))
            else $error("registered capture wrong");
        AST_PRESET: assert property ((m == 2'h0 && prog_pre && !prog_rst) ##0 s_edge
            |=> skip || (feedback_o[c] && !cell_pin_o[c])) else $error("preset missed");
        AST_RESET_TERM: assert property (m == 2'h0 && prog_rst
            |-> cell_pin_o[c] && !feedback_o[c]) else $error("reset term ignored");
        AST_OE_REG: assert property (m == 2'h0 |-> cell_pin_oe_o[c] ==
            (global_cfg_programmed_i & ~shared_enable_pin_n_i)) else $error("shared enable wrong");
        AST_OE_BIDIR: assert property (m == 2'h3 |-> cell_pin_oe_o[c] ==
            (array_programmed_i & pterm_i[c*TERMS_PER_CELL+8])) else $error("direction wrong");
        AST_COMB_OUT: assert property (m == 2'h2 |-> cell_pin_oe_o[c] &&
            cell_pin_o[c] == (s ^ polarity_select_bit_i[c])) else $error("comb output wrong");
    end
endmodule

bind omca_top omca_chk #(
    .N_CELLS        (N_CELLS),
    .TERMS_PER_CELL (TERMS_PER_CELL)
) omca_chk_inst (.*);

// >>> omca_board.sv
/*
 * Board and configuration tool around the cell array.
 * Assumes undriven cell pins are pulled up on the board.
 */
module omca_board (
    // Cell configuration
    input  wire logic [7:0] cfg_a_i,
    input  wire logic [7:0] cfg_b_i,
    // Device drive
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] drv_oe_i,
    // Board drive
    input  wire logic       ext_en_i,
    input  wire logic [7:0] ext_val_i,
    // Resolved pins and global cell
    output logic      [7:0] pin_o,
    output logic            global_o
);
    // ****************************************************************
    // Tool and pin resolution
    // ****************************************************************
    assign global_o = |(~cfg_a_i & ~cfg_b_i);
    assign pin_o = (drv_oe_i & drv_i) | (~drv_oe_i & (ext_en_i ? ext_val_i : 8'hff));
endmodule

// >>> omca_top_tb.sv
/*
 * Self-checking bench for the output cell array.
 * Assumes the board model and checker are compiled alongside.
 */
module omca_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals and tasks
    // ****************************************************************
    logic        clk_i, rst_i, preset_term_i, reset_term_i, array_programmed_i;
    logic        global_cfg_programmed_i, security_fuse_i, clock_pin_i;
    logic        shared_enable_pin_n_i, readback_req_i, readback_valid_o;
    logic        readback_refused_o, ext_en;
    logic [71:0] pterm_i;
    logic [7:0]  arch_select_bit_a_i, arch_select_bit_b_i, polarity_select_bit_i;
    logic [7:0]  cell_pin_i, cell_pin_o, cell_pin_oe_o, feedback_o, ext_val;
    logic [1:0]  dedicated_in_o;
    logic [25:0] readback_data_o;
    int          err_count = 0;
    int          total_checks = 0;
    int          cycles = 0;

    omca_top omca_top_inst (.*);
    omca_board omca_board_inst (.cfg_a_i(arch_select_bit_a_i), .cfg_b_i(arch_select_bit_b_i),
        .drv_i(cell_pin_o), .drv_oe_i(cell_pin_oe_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_o(cell_pin_i), .global_o(global_cfg_programmed_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [25:0] seen, input logic [25:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic pulse();
        clock_pin_i = 1'b1;
        tick(1);
        clock_pin_i = 1'b0;
        tick(1);
    endtask

    task automatic readback(input logic fuse, input logic [25:0] exp);
        security_fuse_i = fuse;
        readback_req_i = 1'b1;
        tick(1);
        readback_req_i = 1'b0;
        check({readback_refused_o, readback_valid_o}, {fuse, ~fuse});
        check(readback_data_o, exp);
        tick(1);
    endtask

    function automatic logic [71:0] pt(input logic [7:0] s, input logic [7:0] d);
        pt = 72'h0;
        for (int c = 0; c < 8; c++) begin
            pt[9*c] = s[c];
            pt[9*c+8] = d[c];
        end
    endfunction

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {rst_i, array_programmed_i, preset_term_i, reset_term_i} = 4'hc;
        {security_fuse_i, clock_pin_i, shared_enable_pin_n_i, readback_req_i, ext_en} = 5'h0;
        {arch_select_bit_a_i, arch_select_bit_b_i, polarity_select_bit_i} = {16'h0, 8'h5a};
        pterm_i = 72'h0;
        ext_val = 8'h00;
        tick(10);
        rst_i = 1'b0;
        tick(1);
        check(cell_pin_o, 8'hff);
        check(feedback_o, 8'h00);
        check(cell_pin_oe_o, 8'hff);
        check(dedicated_in_o, 2'h0);
        shared_enable_pin_n_i = 1'b1;
        tick(1);
        check(cell_pin_oe_o, 8'h00);
        pterm_i = pt(8'h3c, 8'h00);
        pulse();
        check(feedback_o, 8'h99);
        check(cell_pin_o, 8'h66);
        {preset_term_i, pterm_i} = {1'b1, pt(8'hff, 8'h00)};
        tick(2);
        check(feedback_o, 8'h99);
        pulse();
        check({feedback_o, cell_pin_o}, 16'hff00);
        {preset_term_i, reset_term_i} = 2'h1;
        #1;
        check({feedback_o, cell_pin_o}, 16'h00ff);
        tick(1);
        reset_term_i = 1'b0;
        tick(1);
        check(feedback_o, 8'h00);
        {array_programmed_i, polarity_select_bit_i} = {1'b0, 8'hff};
        pulse();
        check(feedback_o, 8'h00);
        {array_programmed_i, polarity_select_bit_i, shared_enable_pin_n_i} = {1'b1, 9'h0};
        {arch_select_bit_a_i, arch_select_bit_b_i, ext_en, ext_val} = {16'hccaa, 9'h1a5};
        pterm_i = pt(8'h44, 8'h08);
        tick(1);
        check(cell_pin_oe_o, 8'h5d);
        check(cell_pin_o & 8'h44, 8'h44);
        check(feedback_o & 8'h22, 8'h20);
        polarity_select_bit_i = 8'hff;
        tick(1);
        check(cell_pin_o & 8'h44, 8'h00);
        {arch_select_bit_a_i, arch_select_bit_b_i, array_programmed_i} = {16'hffff, 1'b0};
        clock_pin_i = 1'b1;
        #1;
        check(cell_pin_oe_o, 8'h00);
        check(dedicated_in_o, 2'h1);
        tick(1);
        clock_pin_i = 1'b0;
        readback(1'b0, 26'h0ffffff);
        readback(1'b1, 26'h0);
        report_and_stop();
    end
endmodule
